// *** include/eeprom_host_pkg.sv ***
/*
  Shared constants and types for the two-wire memory bus controller:
  device word layout, page geometry, bus timing and the command record.
  Assumes a 20 MHz system clock; every cycle count below is derived from it.
*/
package eeprom_host_pkg;

  // ***********************************************************************
  // Timing
  // ***********************************************************************
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned SCL_PERIOD_NS = 2500;
  // Each bit is four quarters; a minimum time, so round up
  localparam int unsigned QUARTER_CYC = (SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WRITE_CYCLE_DURATION_NS = 5000000;
  // Longest programming time, rounded down
  localparam int unsigned WRITE_CYCLE_CYC = WRITE_CYCLE_DURATION_NS / CLK_PERIOD_NS;

  // ***********************************************************************
  // Device word layout
  // ***********************************************************************
  localparam logic [3:0] DEV_TYPE = 4'hA;
  localparam logic RW_READ = 1'h1;
  localparam logic RW_WRITE = 1'h0;
  localparam logic [4:0] PAGE_BYTES = 5'h10;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [7:0] RECOVER_FILL = 8'hFF;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned DATA_W = 8;

  // ***********************************************************************
  // Command record
  // ***********************************************************************
  typedef enum logic [1:0] {
    OP_WRITE,
    OP_READ_CUR,
    OP_READ_RAND,
    OP_RECOVER
  } op_t;

  typedef struct packed {
    op_t op;
    logic [2:0] page;
    logic [7:0] addr;
    logic [4:0] len;
  } cmd_t;

endpackage

// *** design/eeprom_host.sv ***
/*
  Two-wire bus controller for a 2048-byte serial memory, plus the write
  data FIFO that feeds it. Commands arrive on a valid/ready port; write
  bytes on a valid/ready stream; read bytes leave as one-cycle strobes.
  Assumes an external pull-up on the data line and a single target on the
  bus; the serial clock is driven push-pull from a divider.
*/
// Behaviour
// - Data line only changes while clock low, except start and stop.
// - Data falling with clock high is start; issued before every command.
// - Data rising with clock high is stop; ends the transaction.
// - Recovery: start, nine clocks, start, stop returns device to idle.
// - Device word after start carries one-zero-one-zero in its top nibble.
// - Device word bit zero: one reads, zero writes.
// - Byte write: device word, word address, one data byte, then stop.
// - Page write sends up to sixteen data bytes then a stop.
// - Poll with start and device word; acknowledge means programming done.
// - Current read: device word, one byte out, no acknowledge, stop.
// - Random read: dummy write of address, repeated start, current read.
// - Sequential read: acknowledge asks for next byte; no acknowledge ends.
`timescale 1ns/1ps
`default_nettype none

// ***********************************************************************
// Write data FIFO
// ***********************************************************************
module eeprom_wr_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;

  // Extra pointer bit tells full from empty
  assign in_ready_o = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
  assign out_valid_o = wr_ptr != rd_ptr;
  assign out_data_o = mem[rd_ptr[AW-1:0]];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Storage
  always_ff @(posedge sys_clk_i)
  begin
    if (push)
    begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end

  // Pointers
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

// ***********************************************************************
// Bus controller
// ***********************************************************************
module eeprom_host #(
  parameter int unsigned WR_TIMEOUT_CYC = eeprom_host_pkg::WRITE_CYCLE_CYC
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire eeprom_host_pkg::cmd_t cmd_i,
  input wire logic wdata_valid_i,
  output logic wdata_ready_o,
  input wire logic [7:0] wdata_i,
  output logic rdata_valid_o,
  output logic [7:0] rdata_o,
  output logic busy_o,
  output logic done_o,
  output logic nack_o,
  output logic scl_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o
);
  typedef enum {
    ST_IDLE, ST_START, ST_DEVADDR, ST_WORDADDR, ST_WFETCH, ST_WDATA,
    ST_RSTART, ST_RDADDR, ST_RDATA, ST_STOP, ST_DONE,
    ST_RCV_START, ST_RCV_CLK, ST_RCV_START2
  } state_t;

  state_t state;
  eeprom_host_pkg::cmd_t cmd;
  logic [7:0] tx;
  logic [7:0] rx;
  logic [4:0] remaining;
  logic poll;
  logic [31:0] poll_cnt;
  logic ack_ok;
  logic [7:0] qcnt;
  logic [1:0] q;
  logic [3:0] bitcnt;
  logic sda_meta;
  logic sda_sync;
  logic k_start;
  logic k_stop;
  logic k_byte;
  logic tick;
  logic seg_done;
  logic fifo_valid;
  logic [7:0] fifo_data;
  logic next_scl;
  logic next_sda_oe;
  logic [4:0] clamp_len;

  // Zero length means one byte; writes stop at a page
  function automatic logic [4:0] clamp(input eeprom_host_pkg::cmd_t c);
    logic [4:0] n;
    n = (c.len == 5'h00) ? 5'h01 : c.len;
    if (c.op == eeprom_host_pkg::OP_WRITE && n > eeprom_host_pkg::PAGE_BYTES)
    begin
      n = eeprom_host_pkg::PAGE_BYTES;
    end
    return n;
  endfunction

  // Device word: type nibble, page bits, direction
  function automatic logic [7:0] dev_word(input logic [2:0] page, input logic rw);
    return {eeprom_host_pkg::DEV_TYPE, page, rw};
  endfunction

  eeprom_wr_fifo #(
    .WIDTH(eeprom_host_pkg::DATA_W),
    .DEPTH(eeprom_host_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .in_valid_i(wdata_valid_i),
    .in_ready_o(wdata_ready_o),
    .in_data_i(wdata_i),
    .out_valid_o(fifo_valid),
    .out_ready_i(state == ST_WFETCH),
    .out_data_o(fifo_data)
  );

  // Segment kinds per state
  assign k_start = state inside {ST_START, ST_RSTART, ST_RCV_START, ST_RCV_START2};
  assign k_stop = state == ST_STOP;
  assign k_byte = state inside {ST_DEVADDR, ST_WORDADDR, ST_WDATA, ST_RDADDR, ST_RDATA, ST_RCV_CLK};
  assign tick = (k_start || k_stop || k_byte) && qcnt == 8'(eeprom_host_pkg::QUARTER_CYC - 1);
  assign seg_done = tick && q == 2'h3 && (!k_byte || bitcnt == eeprom_host_pkg::ACK_BIT);
  assign clamp_len = clamp(cmd_i);
  assign cmd_ready_o = state == ST_IDLE;
  assign busy_o = state != ST_IDLE;
  assign sda_o = 1'b0;

  // ***********************************************************************
  // Pin sampling
  // ***********************************************************************
  // Two flops before the data line reaches any logic
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
    end
    else
    begin
      sda_meta <= sda_i;
      sda_sync <= sda_meta;
    end
  end

  // ***********************************************************************
  // Bit timing
  // ***********************************************************************
  // Quarter counter; restarts with every segment
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i || !(k_start || k_stop || k_byte) || seg_done)
    begin
      qcnt <= 8'h00;
      q <= 2'h0;
      bitcnt <= 4'h0;
    end
    else if (tick)
    begin
      qcnt <= 8'h00;
      q <= q + 2'h1;
      if (q == 2'h3)
      begin
        bitcnt <= bitcnt + 4'h1;
      end
    end
    else
    begin
      qcnt <= qcnt + 8'h01;
    end
  end

  // Pin levels per quarter; quarter zero only drops the clock so
  // the data line never moves in the same edge as a clock fall
  always_comb
  begin
    next_scl = scl_o;
    next_sda_oe = sda_oe_o;
    if (k_start)
    begin
      next_scl = q >= 2'h2;
      if (q != 2'h0)
      begin
        next_sda_oe = q == 2'h3;
      end
    end
    else if (k_stop)
    begin
      next_scl = q >= 2'h2;
      if (q != 2'h0)
      begin
        next_sda_oe = q != 2'h3;
      end
    end
    else if (k_byte)
    begin
      next_scl = q >= 2'h2;
      if (q != 2'h0)
      begin
        if (state == ST_RDATA)
        begin
          // Acknowledge all but the last byte
          next_sda_oe = bitcnt == eeprom_host_pkg::ACK_BIT && remaining > 5'h01;
        end
        else
        begin
          // MSB first; ninth clock released for the device
          next_sda_oe = bitcnt < eeprom_host_pkg::ACK_BIT && !tx[3'(7 - bitcnt)];
        end
      end
    end
  end

  // Registered pins; idle is clock high, data released
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      scl_o <= 1'b1;
      sda_oe_o <= 1'b0;
    end
    else
    begin
      scl_o <= next_scl;
      sda_oe_o <= next_sda_oe;
    end
  end

  // Sample mid-high: data bits shift in, ninth bit is the answer
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      rx <= 8'h00;
      ack_ok <= 1'b0;
    end
    else if (tick && q == 2'h2 && k_byte)
    begin
      if (bitcnt < eeprom_host_pkg::ACK_BIT)
      begin
        rx <= {rx[6:0], sda_sync};
      end
      else
      begin
        ack_ok <= !sda_sync;
      end
    end
  end

  // ***********************************************************************
  // Transaction sequencer
  // ***********************************************************************
  // Polling window; device may not answer for a whole programming cycle
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i || !poll)
    begin
      poll_cnt <= 32'h0000_0000;
    end
    else if (poll_cnt < WR_TIMEOUT_CYC)
    begin
      poll_cnt <= poll_cnt + 32'h0000_0001;
    end
  end

  // Frame order per command
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      state <= ST_IDLE;
      cmd <= '0;
      tx <= 8'h00;
      remaining <= 5'h00;
      poll <= 1'b0;
      nack_o <= 1'b0;
      done_o <= 1'b0;
      rdata_valid_o <= 1'b0;
      rdata_o <= 8'h00;
    end
    else
    begin
      done_o <= 1'b0;
      rdata_valid_o <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (cmd_valid_i)
          begin
            cmd <= cmd_i;
            remaining <= clamp_len;
            nack_o <= 1'b0;
            poll <= 1'b0;
            state <= (cmd_i.op == eeprom_host_pkg::OP_RECOVER) ? ST_RCV_START : ST_START;
          end
        end
        ST_START:
        begin
          if (seg_done)
          begin
            tx <= dev_word(cmd.page, (cmd.op == eeprom_host_pkg::OP_READ_CUR && !poll));
            state <= ST_DEVADDR;
          end
        end
        ST_DEVADDR:
        begin
          if (seg_done)
          begin
            if (!ack_ok)
            begin
              // Busy device stays silent; retry until the window closes
              if (!poll || poll_cnt >= WR_TIMEOUT_CYC)
              begin
                nack_o <= 1'b1;
                poll <= 1'b0;
              end
              state <= ST_STOP;
            end
            else if (poll)
            begin
              poll <= 1'b0;
              state <= ST_STOP;
            end
            else if (cmd.op == eeprom_host_pkg::OP_READ_CUR)
            begin
              state <= ST_RDATA;
            end
            else
            begin
              tx <= cmd.addr;
              state <= ST_WORDADDR;
            end
          end
        end
        ST_WORDADDR:
        begin
          if (seg_done)
          begin
            if (!ack_ok)
            begin
              nack_o <= 1'b1;
              state <= ST_STOP;
            end
            else if (cmd.op == eeprom_host_pkg::OP_READ_RAND)
            begin
              state <= ST_RSTART;
            end
            else
            begin
              state <= ST_WFETCH;
            end
          end
        end
        ST_WFETCH:
        begin
          // Clock held high and data released while the FIFO is empty
          if (fifo_valid)
          begin
            tx <= fifo_data;
            state <= ST_WDATA;
          end
        end
        ST_WDATA:
        begin
          if (seg_done)
          begin
            remaining <= remaining - 5'h01;
            if (!ack_ok)
            begin
              nack_o <= 1'b1;
              state <= ST_STOP;
            end
            else if (remaining == 5'h01)
            begin
              poll <= 1'b1;
              state <= ST_STOP;
            end
            else
            begin
              state <= ST_WFETCH;
            end
          end
        end
        ST_RSTART:
        begin
          if (seg_done)
          begin
            tx <= dev_word(cmd.page, eeprom_host_pkg::RW_READ);
            state <= ST_RDADDR;
          end
        end
        ST_RDADDR:
        begin
          if (seg_done)
          begin
            if (!ack_ok)
            begin
              nack_o <= 1'b1;
            end
            state <= ack_ok ? ST_RDATA : ST_STOP;
          end
        end
        ST_RDATA:
        begin
          if (seg_done)
          begin
            rdata_o <= rx;
            rdata_valid_o <= 1'b1;
            remaining <= remaining - 5'h01;
            if (remaining == 5'h01)
            begin
              state <= ST_STOP;
            end
          end
        end
        ST_STOP:
        begin
          if (seg_done)
          begin
            state <= poll ? ST_START : ST_DONE;
          end
        end
        ST_DONE:
        begin
          done_o <= 1'b1;
          state <= ST_IDLE;
        end
        ST_RCV_START:
        begin
          if (seg_done)
          begin
            tx <= eeprom_host_pkg::RECOVER_FILL;
            state <= ST_RCV_CLK;
          end
        end
        ST_RCV_CLK:
        begin
          if (seg_done)
          begin
            state <= ST_RCV_START2;
          end
        end
        ST_RCV_START2:
        begin
          if (seg_done)
          begin
            state <= ST_STOP;
          end
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ***********************************************************************
  // Checks
  // ***********************************************************************
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);

  sda_stable_a: assert property (scl_o && $past(scl_o) && (sda_oe_o != $past(sda_oe_o)) |-> $past(k_start || k_stop))
    else $error("data line moved during clock high outside start or stop");
  start_edge_a: assert property ($rose(sda_oe_o) && scl_o |-> $past(k_start) && $past(q) == 2'h3)
    else $error("data fall with clock high outside a start");
  stop_edge_a: assert property ($fell(sda_oe_o) && scl_o |-> $past(k_stop) && $past(q) == 2'h3)
    else $error("data rise with clock high outside a stop");
  ack_release_a: assert property (k_byte && state != ST_RDATA && bitcnt == eeprom_host_pkg::ACK_BIT && q != 2'h0 |=> !sda_oe_o)
    else $error("controller drove the line in the acknowledge slot");
  dev_header_a: assert property (state == ST_DEVADDR |-> tx[7:4] == eeprom_host_pkg::DEV_TYPE && tx[3:1] == cmd.page)
    else $error("device word header or page wrong");
  read_dir_a: assert property (state == ST_RDADDR |-> tx[0] == eeprom_host_pkg::RW_READ)
    else $error("read device word has write direction");
  last_nack_a: assert property (state == ST_RDATA && bitcnt == eeprom_host_pkg::ACK_BIT && q != 2'h0 && remaining == 5'h01 |=> !sda_oe_o)
    else $error("last read byte was acknowledged");
  page_limit_a: assert property (state == ST_WDATA |-> remaining != 5'h00 && remaining <= eeprom_host_pkg::PAGE_BYTES)
    else $error("write burst past one page");
  recover_seq_a: assert property (state == ST_RCV_CLK && seg_done |=> state == ST_RCV_START2 ##1 k_start [*2])
    else $error("recovery clocks not followed by a start");
  poll_bound_a: assert property (poll |-> poll_cnt <= WR_TIMEOUT_CYC)
    else $error("poll window counter overran");
endmodule

`default_nettype wire

// *** test/eeprom_dev_model.sv ***
/*
  Behavioural model of the two-wire serial memory that the controller
  drives: start/stop framing, device word compare, page writes, reads,
  and a self-timed programming window that shuts the bus out.
  Assumes a pull-up on the data line; the bench resolves the wire.
*/
`timescale 1ns/1ps
`default_nettype none

module eeprom_dev_model #(
  parameter int unsigned PROG_NS = 30000
) (
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic mute_i,
  output var logic pull_o
);
  typedef enum logic [2:0] {IDLE, DEV, ADDR, WDATA, RDATA} dev_state_t;
  logic [7:0] mem [0:2047];
  dev_state_t st;
  logic [10:0] ptr;
  logic [2:0] page;
  logic [7:0] sh;
  logic [7:0] rb;
  logic [3:0] cnt;
  logic wrote;
  realtime busy_until;

  // ***********************************************************************
  // Framing
  // ***********************************************************************
  // Known fill so the bench can predict unwritten bytes
  initial
  begin
    st = IDLE;
    ptr = '0;
    page = '0;
    sh = '0;
    rb = '0;
    cnt = '0;
    wrote = 1'b0;
    busy_until = 0;
    pull_o = 1'b0;
    for (int i = 0; i < 2048; i++) mem[i] = i[7:0] ^ 8'h5A;
  end

  // Start in any state; refused while programming
  always @(negedge sda_i)
    if (scl_i === 1'b1)
    begin
      st = ($realtime < busy_until) ? IDLE : DEV;
      cnt = '0;
      pull_o = 1'b0;
    end

  // Stop: standby, and programming if data was taken
  always @(posedge sda_i)
    if (scl_i === 1'b1)
    begin
      if (wrote) busy_until = $realtime + PROG_NS;
      wrote = 1'b0;
      st = IDLE;
      pull_o = 1'b0;
    end

  // ***********************************************************************
  // Bit engine
  // ***********************************************************************
  // Sample on the rising clock only; high-time changes are framing
  always @(posedge scl_i)
    if (st != IDLE && $realtime >= busy_until)
    begin
      if (cnt < 4'h8)
      begin
        sh = {sh[6:0], sda_i};
        cnt = cnt + 4'h1;
      end
      else
      begin
        cnt = '0;
        if (st == RDATA && sda_i) st = IDLE;
      end
    end

  // Drive on the falling clock, pull-down only
  always @(negedge scl_i)
    if (st != IDLE)
    begin
      if (cnt == 4'h8 && st != RDATA)
      begin
        // One assignment per edge, so the wire never glitches
        pull_o = !(st == DEV && (sh[7:4] != 4'hA || mute_i));
        case (st)
          DEV:
          begin
            if (sh[7:4] == 4'hA && !mute_i)
            begin
              page = sh[3:1];
              st = sh[0] ? RDATA : ADDR;
            end
            else
            begin
              st = IDLE;
            end
          end
          ADDR:
          begin
            ptr = {page, sh};
            st = WDATA;
          end
          default:
          begin
            mem[ptr] = sh;
            ptr[3:0] = ptr[3:0] + 4'h1;
            wrote = 1'b1;
          end
        endcase
      end
      else if (st == RDATA && cnt != 4'h8)
      begin
        if (cnt == 4'h0)
        begin
          rb = mem[ptr];
          ptr = ptr + 11'h001;
        end
        pull_o = ~rb[3'(4'h7 - cnt)];
      end
      else
        pull_o = 1'b0;
    end
endmodule

`default_nettype wire

// *** test/eeprom_host_test.sv ***
/*
  Self-checking bench for the two-wire memory controller: absent target,
  recovery, FIFO fill, page writes with wrap, reads with wrap, a stalled
  byte write. Assumes the behavioural memory model and the package.
*/
`timescale 1ns/1ps
`default_nettype none

module eeprom_host_test;
  logic sys_clk_i, nrst_i, cmd_valid_i, cmd_ready_o, wdata_valid_i, wdata_ready_o;
  logic rdata_valid_o, busy_o, done_o, nack_o, scl_o, sda_o, sda_oe_o, sda_w, pull, mute;
  logic [7:0] wdata_i, rdata_o;
  eeprom_host_pkg::cmd_t cmd_i;
  logic [7:0] exp_mem [0:2047];
  logic [7:0] rq [$];
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  int starts, stops, rises, wd;
  int n_errors = 0;
  int total_checks = 0;

  // ***********************************************************************
  // Harness
  // ***********************************************************************
  eeprom_host #(.WR_TIMEOUT_CYC(2000)) eeprom_host_inst (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_i(cmd_i), .wdata_valid_i(wdata_valid_i),
    .wdata_ready_o(wdata_ready_o), .wdata_i(wdata_i), .rdata_valid_o(rdata_valid_o), .rdata_o(rdata_o),
    .busy_o(busy_o), .done_o(done_o), .nack_o(nack_o), .scl_o(scl_o), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o));
  eeprom_dev_model #(.PROG_NS(30000)) eeprom_dev_model_inst (.scl_i(scl_o), .sda_i(sda_w),
    .mute_i(mute), .pull_o(pull));

  // Open-drain data line with pull-up
  assign sda_w = ~((sda_oe_o & ~sda_o) | pull);

  initial
  begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  // Wire watcher at the falling edge, away from register updates
  always @(negedge sys_clk_i)
  begin
    if (scl_q && scl_o && sda_q && !sda_w) starts++;
    if (scl_q && scl_o && !sda_q && sda_w) stops++;
    if (!scl_q && scl_o) rises++;
    if (rdata_valid_o === 1'b1) rq.push_back(rdata_o);
    scl_q <= scl_o;
    sda_q <= sda_w;
  end

  // Hang guard, well above the longest expected run
  initial
  begin
    wd = 0;
    forever
    begin
      @(posedge sys_clk_i);
      wd++;
      if (wd == 80000)
      begin
        n_errors++;
        summarize();
      end
    end
  end

  // ***********************************************************************
  // Shared tasks
  // ***********************************************************************
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic note(input string s);
    $display("test %s ended, errors so far %0d", s, n_errors);
  endtask

  // Offer after a rising edge, accepted at the next rising edge, then wait done
  task automatic run_cmd(input eeprom_host_pkg::op_t op, input logic [2:0] pg, input logic [7:0] ad,
                         input logic [4:0] ln);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    cmd_i <= '{op, pg, ad, ln};
    cmd_valid_i <= 1'b1;
    @(negedge sys_clk_i);
    check(8'(cmd_ready_o), 8'h01);
    starts = 0;
    stops = 0;
    rises = 0;
    rq.delete();
    @(posedge sys_clk_i);
    cmd_valid_i <= 1'b0;
    while (done_o !== 1'b1 && n < 30000)
    begin
      @(negedge sys_clk_i);
      n++;
    end
    check(8'(done_o), 8'h01);
  endtask

  task automatic chk_read(input logic [10:0] base, input int n);
    check(8'(rq.size()), 8'(n));
    for (int k = 0; k < n; k++) check(rq[k], exp_mem[11'(base + k)]);
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ***********************************************************************
  // Scenarios
  // ***********************************************************************
  task automatic t_absent;
    mute = 1'b1;
    run_cmd(eeprom_host_pkg::OP_READ_CUR, 3'h0, 8'h00, 5'h02);
    check(8'(nack_o), 8'h01);
    check(8'(rq.size()), 8'h00);
    mute = 1'b0;
    note("absent");
  endtask

  task automatic t_recover;
    run_cmd(eeprom_host_pkg::OP_RECOVER, 3'h0, 8'h00, 5'h01);
    check(8'(nack_o), 8'h00);
    check(8'({starts[3:0], stops[3:0]}), 8'h21);
    check(8'(rises), 8'h0C);
    note("recover");
  endtask

  // Fill until the FIFO refuses; nothing drains it meanwhile
  task automatic t_fifo;
    int n;
    n = 0;
    @(posedge sys_clk_i);
    wdata_valid_i <= 1'b1;
    wdata_i <= 8'hC0;
    repeat (40)
    begin
      @(negedge sys_clk_i);
      if (wdata_ready_o !== 1'b1) break;
      @(posedge sys_clk_i);
      n++;
      wdata_i <= 8'hC0 ^ 8'(n);
    end
    @(posedge sys_clk_i);
    wdata_valid_i <= 1'b0;
    check(8'(n), 8'h20);
    note("fifo");
  endtask

  task automatic t_page;
    for (int k = 0; k < 16; k++) exp_mem[{3'h3, 4'h2, 4'(4'hE + k)}] = 8'hC0 ^ 8'(k);
    for (int k = 0; k < 16; k++) exp_mem[{3'h5, 8'(k)}] = 8'hC0 ^ 8'(16 + k);
    run_cmd(eeprom_host_pkg::OP_WRITE, 3'h3, 8'h2E, 5'h10);
    check(8'(nack_o), 8'h00);
    check(8'(starts > 2), 8'h01);
    run_cmd(eeprom_host_pkg::OP_WRITE, 3'h5, 8'h00, 5'h14);
    check(8'(nack_o), 8'h00);
    note("page");
  endtask

  task automatic t_readback;
    run_cmd(eeprom_host_pkg::OP_READ_RAND, 3'h3, 8'h20, 5'h10);
    chk_read(11'h320, 16);
    run_cmd(eeprom_host_pkg::OP_READ_RAND, 3'h5, 8'h0F, 5'h02);
    chk_read(11'h50F, 2);
    note("readback");
  endtask

  task automatic t_wrap;
    run_cmd(eeprom_host_pkg::OP_READ_RAND, 3'h7, 8'hFE, 5'h03);
    chk_read(11'h7FE, 3);
    run_cmd(eeprom_host_pkg::OP_READ_CUR, 3'h0, 8'h00, 5'h01);
    chk_read(11'h001, 1);
    check(8'({starts[3:0], stops[3:0]}), 8'h11);
    check(8'(rises), 8'h14);
    note("wrap");
  endtask

  // Byte write with an empty FIFO: the bus must wait for the byte
  task automatic t_stall;
    exp_mem[11'h010] = 8'h3C;
    fork
      run_cmd(eeprom_host_pkg::OP_WRITE, 3'h0, 8'h10, 5'h01);
      begin
        repeat (1500) @(negedge sys_clk_i);
        check(8'({busy_o, scl_o, wdata_ready_o}), 8'h07);
        @(posedge sys_clk_i);
        wdata_i <= 8'h3C;
        wdata_valid_i <= 1'b1;
        @(posedge sys_clk_i);
        wdata_valid_i <= 1'b0;
      end
    join
    check(8'(nack_o), 8'h00);
    run_cmd(eeprom_host_pkg::OP_READ_RAND, 3'h0, 8'h10, 5'h01);
    chk_read(11'h010, 1);
    note("stall");
  endtask

  // ***********************************************************************
  // Main sequence
  // ***********************************************************************
  initial
  begin
    nrst_i = 1'b0;
    cmd_valid_i = 1'b0;
    cmd_i = '0;
    wdata_valid_i = 1'b0;
    wdata_i = '0;
    mute = 1'b0;
    for (int i = 0; i < 2048; i++) exp_mem[i] = i[7:0] ^ 8'h5A;
    repeat (12) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    @(negedge sys_clk_i);
    check(8'({cmd_ready_o, busy_o, scl_o, sda_oe_o}), 8'h0A);
    t_absent();
    t_recover();
    t_fifo();
    t_page();
    t_readback();
    t_wrap();
    t_stall();
    summarize();
  end
endmodule

`default_nettype wire
